//--- bss_boot_selector.sv
// Purpose: reset-time boot source selection and extra-array config bytes
// Assumes: core_clk 10 MHz; reset sequenced by rst; pins asynchronous
// Notes: config bytes live in flops; lock level gates programmer access
//
// Operation
// - access pin high and fetch strobe low at reset release force loader.
// - pin forcing beats fuse, status byte and vector byte.
// - pins sampled only at reset release; may be released afterwards.
// - without forcing, fuse one picks app; fuse zero passes the choice to the status and vector bytes.
// - fuse checked in hardware before any fetch is allowed.
// - customer loader address is vector byte followed by low byte 00h.
// - vector byte FCh, the default, means no customer loader.
// - both lock bits one means no restriction.
// - lock bit a zero, bit b one blocks in-system programming.
// - lock bit b zero blocks in-system programming and verify.
// - access pin high fetches internal flash; low fetches external.
// - service calls enter through fixed address FFF0h.
// - loader starts at F800h; app, picked by fuse one or a cleared status byte, starts at 0000h.
`timescale 1ns/1ps
module bss_boot_selector
  import bss_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = BSS_MAKER_ID, // arbitrary value
  parameter logic [7:0] FAMILY_ID = BSS_FAMILY_ID, // arbitrary value
  parameter logic [7:0] MEMSIZE_ID = BSS_MEMSIZE_ID, // arbitrary value
  parameter logic [7:0] NAMEREV_ID = BSS_NAMEREV_ID // arbitrary value
) (
  // clocking
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  // boot pins
  input wire logic codeSourceSelectPin,
  input wire logic programFetchStrobeIn,
  output logic programFetchStrobeOut,
  output logic programFetchStrobeOe_n,
  // extra array byte port
  input wire logic [2:0] cfgAddr,
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgWrData,
  input wire logic cfgIsp,
  output logic [7:0] cfgRdData,
  output logic cfgRdValid,
  output logic cfgRefused,
  // flash access gating from in-system interface
  input wire logic ispProgramReq,
  input wire logic ispVerifyReq,
  output logic ispProgramGrant,
  output logic ispVerifyGrant,
  // boot outcome
  output logic bootReady,
  output logic [15:0] bootAddress,
  output bss_pkg::bss_boot_type bootSource,
  output logic fetchExternal,
  output logic [15:0] serviceEntry,
  output logic [1:0] lockLevelField
);
  import bss_pkg::*;

  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic accessPinSync;
  logic strobePinSync;
  logic forcedReg;
  logic forcedNext;
  logic accessLatchReg;
  logic [7:0] vectorReg;
  logic [7:0] hwCopyReg;
  logic [7:0] statusReg;
  logic [7:0] lockReg;
  logic [7:0] rdDataReg;
  logic rdValidReg;
  logic refusedReg;
  logic readyReg;
  logic [15:0] addrReg;
  logic [15:0] addrNext;
  bss_boot_type srcReg;
  bss_boot_type srcNext;
  bss_state_type stateReg;
  logic loaderFuse;
  logic lockBitA;
  logic lockBitB;
  logic programBlocked;
  logic verifyBlocked;
  logic writeOk;

  // ------------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------------

  // both pins cross into the core clock through three flops and an agreement flop
  bss_sync #(.INIT(1'b1)) uAccessSync (
    .core_clk(core_clk),
    .rst(rst),
    .clkEn(clkEn),
    .pinIn(codeSourceSelectPin),
    .pinOut(accessPinSync)
  );

  bss_sync #(.INIT(1'b1)) uStrobeSync (
    .core_clk(core_clk),
    .rst(rst),
    .clkEn(clkEn),
    .pinIn(programFetchStrobeIn),
    .pinOut(strobePinSync)
  );

  // forcing condition, frozen after the decision
  assign forcedNext = accessPinSync & ~strobePinSync;

  // ------------------------------------------------------------------
  // boot sequencer
  // ------------------------------------------------------------------

  // reset wait lets the synchronisers settle, then one decision cycle
  logic [2:0] settleCnt;
  logic settleDone;
  // pin agreement lands on the fourth edge, so sample on the fifth
  localparam logic [2:0] SETTLE_LAST = 3'h4;

  assign settleDone = (stateReg == BSS_ST_RESET) &&
                      (settleCnt == SETTLE_LAST);

  // settle counter, stops at its last value
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settleCnt <= 3'h0;
    end else if (clkEn && stateReg == BSS_ST_RESET &&
                 settleCnt != SETTLE_LAST) begin
      settleCnt <= settleCnt + 3'h1;
    end
  end

  // state sequence: settle, decide once, run until next reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stateReg <= BSS_ST_RESET;
    end else if (clkEn) begin
      case (stateReg)
        BSS_ST_RESET: begin
          if (settleDone) begin
            stateReg <= BSS_ST_DECIDE;
          end
        end
        BSS_ST_DECIDE: stateReg <= BSS_ST_RUN;
        BSS_ST_RUN: stateReg <= BSS_ST_RUN;
        default: stateReg <= BSS_ST_RESET;
      endcase
    end
  end

  // pins captured once, at the release point only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      forcedReg <= 1'b0;
      accessLatchReg <= 1'b1;
    end else if (clkEn && settleDone) begin
      forcedReg <= forcedNext;
      accessLatchReg <= accessPinSync;
    end
  end

  // decision logic
  assign loaderFuse = hwCopyReg[BSS_HW_FUSE_BIT];

  always_comb begin
    srcNext = BSS_BOOT_APP;
    addrNext = BSS_APP_START;
    if (forcedReg) begin
      srcNext = BSS_BOOT_LOADER;
      addrNext = BSS_LOADER_START;
    end else if (loaderFuse) begin
      srcNext = BSS_BOOT_APP;
      addrNext = BSS_APP_START;
    end else if (statusReg != BSS_STATUS_CLEARED &&
                 vectorReg != BSS_VECTOR_DEFAULT) begin
      srcNext = BSS_BOOT_CUSTOMER;
      addrNext = {vectorReg, BSS_ZERO_BYTE};
    end else if (statusReg != BSS_STATUS_CLEARED) begin
      srcNext = BSS_BOOT_LOADER;
      addrNext = BSS_LOADER_START;
    end else begin
      srcNext = BSS_BOOT_APP;
      addrNext = BSS_APP_START;
    end
  end

  // ready flag; fetch held off until it rises
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      readyReg <= 1'b0;
    end else if (clkEn && stateReg == BSS_ST_DECIDE) begin
      readyReg <= 1'b1;
    end
  end

  // start address and source, captured with the decision
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      srcReg <= BSS_BOOT_LOADER;
      addrReg <= BSS_LOADER_START;
    end else if (clkEn && stateReg == BSS_ST_DECIDE) begin
      srcReg <= srcNext;
      addrReg <= addrNext;
    end
  end

  assign bootReady = readyReg;
  assign bootAddress = addrReg;
  assign bootSource = srcReg;
  assign fetchExternal = ~accessLatchReg;
  assign serviceEntry = BSS_SERVICE_ENTRY;

  // strobe pin is an input during reset, released to output afterwards
  assign programFetchStrobeOut = 1'b1;
  assign programFetchStrobeOe_n = ~readyReg;

  // ------------------------------------------------------------------
  // lock level
  // ------------------------------------------------------------------
  assign lockBitA = lockReg[BSS_LOCK_A_BIT];
  assign lockBitB = lockReg[BSS_LOCK_B_BIT];
  assign lockLevelField = {lockBitB, lockBitA};
  // level 1: both bits one, no restriction
  // level 2: bit a zero, programming blocked
  // level 3: bit b zero, programming and verify blocked
  assign verifyBlocked = ~lockBitB;
  assign programBlocked = ~lockBitA | ~lockBitB;
  assign ispProgramGrant = ispProgramReq & ~programBlocked;
  assign ispVerifyGrant = ispVerifyReq & ~verifyBlocked;

  // ------------------------------------------------------------------
  // extra array bytes
  // ------------------------------------------------------------------

  // isp writes refused under programming lock; identity bytes read-only
  logic ispWriteBlocked;
  logic slotWritable;
  assign ispWriteBlocked = cfgIsp & programBlocked;
  assign slotWritable = cfgAddr <= BSS_IDX_LOCK;
  assign writeOk = ~ispWriteBlocked & slotWritable;

  // write strobes and read decode
  logic wrVector;
  logic wrHwCopy;
  logic wrStatus;
  logic wrLock;
  logic wrRefused;
  logic rdRefused;
  logic rdAccepted;
  logic [7:0] rdDataNext;

  // one strobe per writable byte, accepted writes only
  assign wrVector = clkEn && cfgWrite && writeOk &&
                    cfgAddr == BSS_IDX_VECTOR;
  assign wrHwCopy = clkEn && cfgWrite && writeOk &&
                    cfgAddr == BSS_IDX_HWCOPY;
  assign wrStatus = clkEn && cfgWrite && writeOk &&
                    cfgAddr == BSS_IDX_STATUS;
  assign wrLock = clkEn && cfgWrite && writeOk &&
                  cfgAddr == BSS_IDX_LOCK;

  // customer loader vector byte
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vectorReg <= BSS_VECTOR_DEFAULT;
    end else if (wrVector) begin
      vectorReg <= cfgWrData;
    end
  end

  // copy of the hardware byte, fuse in bit 6
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hwCopyReg <= BSS_HWCOPY_DEFAULT;
    end else if (wrHwCopy) begin
      hwCopyReg <= cfgWrData;
    end
  end

  // boot status byte, cleared by the programmer after loading
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      statusReg <= BSS_STATUS_DEFAULT;
    end else if (wrStatus) begin
      statusReg <= cfgWrData;
    end
  end

  // lock byte; upper bits forced set regardless of writer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lockReg <= BSS_LOCK_DEFAULT;
    end else if (wrLock) begin
      lockReg <= cfgWrData | ~BSS_LOCK_FIELD_MASK;
    end
  end

  // read mux over all eight byte slots
  always_comb begin
    rdDataNext = BSS_ZERO_BYTE;
    case (cfgAddr)
      BSS_IDX_VECTOR: rdDataNext = vectorReg;
      BSS_IDX_HWCOPY: rdDataNext = hwCopyReg;
      BSS_IDX_STATUS: rdDataNext = statusReg;
      BSS_IDX_LOCK: rdDataNext = lockReg;
      BSS_IDX_MAKER: rdDataNext = MAKER_ID;
      BSS_IDX_FAMILY: rdDataNext = FAMILY_ID;
      BSS_IDX_MEMSIZE: rdDataNext = MEMSIZE_ID;
      default: rdDataNext = NAMEREV_ID;
    endcase
  end

  // refusals; a refused write masks a read in the same cycle
  assign wrRefused = cfgWrite && !writeOk;
  assign rdRefused = !wrRefused && cfgRead && cfgIsp && verifyBlocked;
  assign rdAccepted = !wrRefused && cfgRead && !(cfgIsp && verifyBlocked);

  // registered read port; isp verify blocked at lock level 3
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdDataReg <= BSS_ZERO_BYTE;
      rdValidReg <= 1'b0;
      refusedReg <= 1'b0;
    end else if (clkEn) begin
      rdValidReg <= rdAccepted;
      refusedReg <= wrRefused | rdRefused;
      if (rdRefused) begin
        rdDataReg <= BSS_ZERO_BYTE;
      end else if (rdAccepted) begin
        rdDataReg <= rdDataNext;
      end
    end
  end

  assign cfgRdData = rdDataReg;
  assign cfgRdValid = rdValidReg;
  assign cfgRefused = refusedReg;
endmodule

//--- bss_pkg.sv
// Purpose: shared constants for the boot source selector
// Assumes: one core clock, asynchronous active-high reset
// Notes: extra-array byte indices are local choices
package bss_pkg;
  // extra array byte indices
  localparam logic [2:0] BSS_IDX_VECTOR = 3'h0;
  localparam logic [2:0] BSS_IDX_HWCOPY = 3'h1;
  localparam logic [2:0] BSS_IDX_STATUS = 3'h2;
  localparam logic [2:0] BSS_IDX_LOCK = 3'h3;
  localparam logic [2:0] BSS_IDX_MAKER = 3'h4;
  localparam logic [2:0] BSS_IDX_FAMILY = 3'h5;
  localparam logic [2:0] BSS_IDX_MEMSIZE = 3'h6;
  localparam logic [2:0] BSS_IDX_NAMEREV = 3'h7;
  localparam int BSS_NUM_BYTES = 8;
  // reset values
  localparam logic [7:0] BSS_VECTOR_DEFAULT = 8'hfc;
  localparam logic [7:0] BSS_HWCOPY_DEFAULT = 8'hbb;
  localparam logic [7:0] BSS_STATUS_DEFAULT = 8'hff;
  localparam logic [7:0] BSS_LOCK_DEFAULT = 8'hff;
  localparam logic [7:0] BSS_STATUS_CLEARED = 8'h00;
  localparam logic [7:0] BSS_ZERO_BYTE = 8'h00;
  // identity bytes: values arbitrary
  localparam logic [7:0] BSS_MAKER_ID = 8'h11;
  localparam logic [7:0] BSS_FAMILY_ID = 8'h22;
  localparam logic [7:0] BSS_MEMSIZE_ID = 8'h33;
  localparam logic [7:0] BSS_NAMEREV_ID = 8'h44;
  // field positions
  localparam int BSS_HW_FUSE_BIT = 6;
  localparam int BSS_LOCK_A_BIT = 0;
  localparam int BSS_LOCK_B_BIT = 1;
  localparam logic [7:0] BSS_LOCK_FIELD_MASK = 8'h03;
  // addresses
  localparam logic [15:0] BSS_APP_START = 16'h0000;
  localparam logic [15:0] BSS_LOADER_START = 16'hf800;
  localparam logic [15:0] BSS_SERVICE_ENTRY = 16'hfff0;
  // boot decision
  typedef enum logic [1:0] {
    BSS_BOOT_APP,
    BSS_BOOT_LOADER,
    BSS_BOOT_CUSTOMER
  } bss_boot_type;
  // sequencer states
  typedef enum logic [1:0] {
    BSS_ST_RESET,
    BSS_ST_DECIDE,
    BSS_ST_RUN
  } bss_state_type;
endpackage

//--- bss_sync.sv
// Purpose: three-stage pin synchroniser with agreement check
// Assumes: input asynchronous to core_clk
// Notes: output moves only once stages two and three agree
`timescale 1ns/1ps
module bss_sync #(
  parameter logic INIT = 1'b1
) (
  // clocking
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  // pin and result
  input wire logic pinIn,
  output logic pinOut
);
  logic stageA;
  logic stageB;
  logic stageC;

  // capture chain
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // idle level, so release shows no false change
      stageA <= INIT;
      stageB <= INIT;
      stageC <= INIT;
    end else if (clkEn) begin
      stageA <= pinIn;
      stageB <= stageA;
      stageC <= stageB;
    end
  end

  // accept level once two late stages agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinOut <= INIT;
    end else if (clkEn && (stageB == stageC)) begin
      pinOut <= stageC;
    end
  end
endmodule

//--- bss_boot_selector_props.sv
// Purpose: port checker for the boot selector
// Assumes: bound into bss_boot_selector
// Notes: relations between outputs and their causes
`timescale 1ns/1ps
module bss_checker
  import bss_pkg::*;
(
  // clocking
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  // config port
  input wire logic cfgWrite,
  input wire logic cfgIsp,
  input wire logic cfgRefused,
  // grants
  input wire logic ispProgramReq,
  input wire logic ispVerifyReq,
  input wire logic ispProgramGrant,
  input wire logic ispVerifyGrant,
  input wire logic [1:0] lockLevelField,
  // boot outcome
  input wire logic programFetchStrobeOe_n,
  input wire logic bootReady,
  input wire logic [15:0] bootAddress,
  input wire bss_pkg::bss_boot_type bootSource,
  input wire logic fetchExternal,
  input wire logic [15:0] serviceEntry
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // fixed service entry
  property p_svc; serviceEntry == 16'hfff0; endproperty
  a_svc: assert property (p_svc) else $error("service entry moved");
  // grants follow the lock field
  property p_prog;
    ispProgramGrant == (ispProgramReq && lockLevelField == 2'b11);
  endproperty
  a_prog: assert property (p_prog) else $error("program grant wrong");
  property p_ver; ispVerifyGrant == (ispVerifyReq && lockLevelField[1]); endproperty
  a_ver: assert property (p_ver) else $error("verify grant wrong");
  property p_iswr;
    cfgWrite && clkEn && cfgIsp && lockLevelField != 2'b11 |=> cfgRefused;
  endproperty
  a_iswr: assert property (p_iswr) else $error("locked write taken");
  // no fetch strobe drive before the decision
  property p_hold; !bootReady |-> programFetchStrobeOe_n; endproperty
  a_hold: assert property (p_hold) else $error("strobe driven early");
  property p_ldr;
    bootReady && bootSource == BSS_BOOT_LOADER |-> bootAddress == 16'hf800;
  endproperty
  a_ldr: assert property (p_ldr) else $error("loader address wrong");
  property p_app;
    bootReady && bootSource == BSS_BOOT_APP |-> bootAddress == 16'h0000;
  endproperty
  a_app: assert property (p_app) else $error("app address wrong");
  property p_cust;
    bootReady && bootSource == BSS_BOOT_CUSTOMER
      |-> bootAddress[7:0] == 8'h00 && bootAddress[15:8] != 8'hfc;
  endproperty
  a_cust: assert property (p_cust) else $error("customer address wrong");
  property p_keep;
    bootReady |=> bootReady && $stable(bootAddress) && $stable(fetchExternal);
  endproperty
  a_keep: assert property (p_keep) else $error("boot outcome moved");
endmodule

bind bss_boot_selector bss_checker bss_checker_inst (.*);

//--- bss_pin_model.sv
// Purpose: board and programmer side of the boot pins
// Assumes: strobe line has a pull-up
// Notes: strobe forcing held 8 cycles past reset release; access pin held throughout
`timescale 1ns/1ps
module bss_pin_model (
  // clocking
  input wire logic core_clk,
  input wire logic rst,
  // scenario controls
  input wire logic forceBoot,
  input wire logic accessHigh,
  // device side of the strobe pin
  input wire logic programFetchStrobeOut,
  input wire logic programFetchStrobeOe_n,
  output logic codeSourceSelectPin,
  output logic programFetchStrobeIn
);
  int held;
  // count cycles since reset release
  always @(posedge core_clk or posedge rst) begin
    if (rst) held <= 0;
    else if (held < 8) held <= held + 1;
  end
  assign codeSourceSelectPin = accessHigh;
  // pulled high unless forcing around release
  assign programFetchStrobeIn = !programFetchStrobeOe_n ?
    programFetchStrobeOut : !(forceBoot && (rst || held < 8));
endmodule

//--- bss_boot_selector_tb.sv
// Purpose: self-checking bench for the boot selector
// Assumes: pin model on the strobe and access pins
// Notes: expectations queued, outcomes popped by a monitor
`timescale 1ns/1ps
module bss_boot_selector_tb;
  import bss_pkg::*;
  localparam logic [17:0] NONE = 18'h3ffff;
  logic core_clk = 0, rst = 1, clkEn = 1, cfgWrite = 0, cfgRead = 0;
  logic cfgIsp = 0, ispProgramReq = 0, ispVerifyReq = 0, forceBoot = 0;
  logic accessHigh = 1, rdyPrev = 0;
  logic [2:0] cfgAddr = 0;
  logic [7:0] cfgWrData = 0, cfgRdData, vec;
  logic codeSourceSelectPin, programFetchStrobeIn, programFetchStrobeOut;
  logic programFetchStrobeOe_n, cfgRdValid, cfgRefused, bootReady;
  logic ispProgramGrant, ispVerifyGrant, fetchExternal;
  logic [15:0] bootAddress, serviceEntry;
  logic [1:0] lockLevelField;
  bss_boot_type bootSource;
  logic [17:0] q[$];
  logic [7:0] ids [4] = '{BSS_MAKER_ID, BSS_FAMILY_ID, BSS_MEMSIZE_ID,
                          BSS_NAMEREV_ID};
  int n_errors = 0, cmp_count = 0;

  always #50 core_clk = ~core_clk;
  bss_boot_selector bss_boot_selector_inst (.*);
  bss_pin_model bss_pin_model_inst (.*);

  task automatic cyc;
    @(posedge core_clk);
    #1;
  endtask
  // one config access, held over one edge
  task automatic acc(logic w, r, i, logic [2:0] a, logic [7:0] d,
                     logic [17:0] ex);
    cfgWrite = w; cfgRead = r; cfgIsp = i; cfgAddr = a; cfgWrData = d;
    ispProgramReq = 1'($urandom); ispVerifyReq = 1'($urandom);
    if (ex != NONE) q.push_back(ex);
    cyc;
  endtask
  task automatic idle;
    cfgWrite = 0; cfgRead = 0;
    cyc;
  endtask
  // reset with pins set, load bytes, await the decision
  task automatic boot(logic a, f, logic [7:0] hw, st, v, logic [17:0] ex);
    rst = 1; accessHigh = a; forceBoot = f;
    repeat (10) cyc;
    rst = 0;
    acc(1, 0, 0, BSS_IDX_HWCOPY, hw, NONE);
    acc(1, 0, 0, BSS_IDX_STATUS, st, NONE);
    acc(1, 0, 0, BSS_IDX_VECTOR, v, NONE);
    idle;
    q.push_back(ex);
    for (int k = 0; k < 20 && !bootReady; k++) cyc;
    cyc;
  endtask
  task automatic chk(logic [17:0] got);
    logic [17:0] e;
    e = q.size() ? q.pop_front() : NONE;
    cmp_count++;
    if (e !== got) begin
      n_errors++;
      $display("ERROR outcome expected %h seen %h", e, got);
    end
  endtask
  task automatic results;
    if (q.size() != 0) n_errors++;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // monitor pops the oldest note per outcome
  always @(negedge core_clk) begin
    if (bootReady && !rdyPrev) chk({1'b1, fetchExternal, bootAddress});
    if (cfgRefused) chk(18'h10000);
    else if (cfgRdValid) chk({10'h0, cfgRdData});
    rdyPrev <= bootReady;
  end

  // watchdog
  initial begin
    #400000;
    n_errors++;
    results;
  end

  initial begin
    void'($urandom(32'h50384a9c));
    vec = 8'($urandom_range(8'h01, 8'hf0));
    boot(1, 1, 8'hff, 8'h00, 8'h10, {2'b10, 16'hf800});
    boot(1, 0, 8'hff, 8'hff, vec, {2'b10, 16'h0000});
    boot(1, 0, 8'hbb, 8'hff, vec, {2'b10, vec, 8'h00});
    boot(1, 0, 8'hbb, 8'hff, 8'hfc, {2'b10, 16'hf800});
    boot(1, 0, 8'hbb, 8'h00, vec, {2'b10, 16'h0000});
    boot(0, 1, 8'hbb, 8'h00, vec, {2'b11, 16'h0000});
    // identity bytes, then lock levels in turn
    for (int i = 0; i < 4; i++)
      acc(0, 1, 0, 3'(BSS_IDX_MAKER + i), 0, {10'h0, ids[i]});
    acc(0, 1, 0, BSS_IDX_LOCK, 0, {10'h0, 8'hff});
    acc(0, 1, 1, BSS_IDX_VECTOR, 0, {10'h0, vec});
    acc(1, 0, 0, 3'h4, 8'h5a, 18'h10000);
    acc(1, 0, 0, BSS_IDX_LOCK, 8'hfe, NONE);
    acc(1, 0, 1, BSS_IDX_VECTOR, 8'h33, 18'h10000);
    acc(0, 1, 1, BSS_IDX_LOCK, 0, {10'h0, 8'hfe});
    acc(1, 0, 0, BSS_IDX_LOCK, 8'hfd, NONE);
    acc(0, 1, 1, BSS_IDX_VECTOR, 0, 18'h10000);
    acc(0, 1, 0, BSS_IDX_VECTOR, 0, {10'h0, vec});
    idle;
    repeat (3) cyc;
    results;
  end
endmodule
